// File: design/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
    parameter int width = 8,
    parameter int depth = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [width-1:0] out_data,
    // fill level
    output logic [$clog2(depth+1)-1:0] level
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem_q [depth];
    logic [aw-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [aw:0]      cnt_q, cnt_d;
    logic             push, pop;

    // handshake and pointer next values
    always_comb begin
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        wr_d = push ? ((wr_q == aw'(depth - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == aw'(depth - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (aw+1)'(push) - (aw+1)'(pop);
    end

    // honest full and empty
    assign in_ready  = (cnt_q != (aw+1)'(depth));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = ($clog2(depth+1))'(cnt_q);

    // pointer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// File: design/host_bus_port.sv
// host parallel bus port with per-channel transmit and receive fifos
// Behaviour
// - the port offers eight tri-state data lines carrying data both ways.
// - with the separate-strobe style, control pin one is a low read strobe and pin zero a low write strobe.
// - a selected read returns the internal register chosen by the seven address lines.
// - a read under dma grant returns the channel's receive fifo byte and ignores the address.
// - a selected write from the data lines loads the scratch register or pushes the transmit fifo; writes to other addresses are ignored.
// - with the single-strobe style, pin one is a high enable if the polarity strap is low, else a low strobe.
// - with the single-strobe style, pin zero gives the transfer direction, high for read.
// - each channel has its own 64-byte fifo in each direction.
`timescale 1ns/10ps
module host_bus_port #(
    parameter int depth = host_port_pkg::fifo_depth
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // host bus pins
    input  wire logic [7:0]  host_data_lines_in,
    output logic      [7:0]  host_data_lines_out,
    output logic             host_data_lines_oe,
    input  wire logic [6:0]  register_address_lines,
    input  wire logic        select_n,
    input  wire logic        control_input_one,
    input  wire logic        control_input_zero,
    input  wire logic [1:0]  dma_grant,
    // straps
    input  wire logic        bus_style_strap,
    input  wire logic        strobe_polarity_strap,
    // transmit fifo drains, one per channel
    output logic [1:0]       tx_valid,
    input  wire logic [1:0]  tx_ready,
    output logic [15:0]      tx_data,
    // receive fifo fills, one per channel
    input  wire logic [1:0]  rx_valid,
    output logic [1:0]       rx_ready,
    input  wire logic [15:0] rx_data
);
    localparam int lw = $clog2(depth+1);

    // two-stage synchronisers for all host bus and strap pins, 22 bits wide
    logic [21:0] s1_q, s2_q;
    logic [7:0]  din;
    logic [6:0]  addr;
    logic        sel_n, c1, c0, style, pol;
    logic [1:0]  grant;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 22'h380000;                            // select and both strobes idle high
            s2_q <= 22'h380000;
        end else begin
            s1_q <= {select_n, control_input_one, control_input_zero, dma_grant, bus_style_strap,
                     strobe_polarity_strap, register_address_lines, host_data_lines_in};
            s2_q <= s1_q;
        end
    end

    always_comb begin
        {sel_n, c1, c0, grant, style, pol, addr, din} = s2_q;
    end

    // strobe decode from the straps
    logic rd_act, wr_act, acc_sel, acc_dma, chan_dma;
    always_comb begin
        if (!style) begin
            rd_act = !c1;
            wr_act = !c0;
        end else begin
            rd_act = (pol ? !c1 : c1) && c0;
            wr_act = (pol ? !c1 : c1) && !c0;
        end
        acc_sel  = !sel_n;
        acc_dma  = (grant != 2'b00) && sel_n;
        chan_dma = grant[1];
    end

    // per-channel fifos, both directions
    logic [1:0]    txf_in_valid, txf_in_ready, rxf_out_valid, rxf_out_ready;
    logic [15:0]   rxf_out_data;
    logic [lw-1:0] tx_lvl [2];
    logic [lw-1:0] rx_lvl [2];
    logic [7:0]    wbyte_q, wbyte_d;

    for (genvar ch = 0; ch < host_port_pkg::channel_count; ch++) begin : g_ch
        byte_fifo #(.width(8), .depth(depth)) u_tx (
            .clk(clk), .rst(rst),
            .in_valid(txf_in_valid[ch]), .in_ready(txf_in_ready[ch]), .in_data(wbyte_q),
            .out_valid(tx_valid[ch]), .out_ready(tx_ready[ch]), .out_data(tx_data[ch*8 +: 8]),
            .level(tx_lvl[ch]));
        byte_fifo #(.width(8), .depth(depth)) u_rx (
            .clk(clk), .rst(rst),
            .in_valid(rx_valid[ch]), .in_ready(rx_ready[ch]), .in_data(rx_data[ch*8 +: 8]),
            .out_valid(rxf_out_valid[ch]), .out_ready(rxf_out_ready[ch]),
            .out_data(rxf_out_data[ch*8 +: 8]), .level(rx_lvl[ch]));
    end

    // sequencer: one action per strobe, taken on its leading edge
    host_port_pkg::cycle_state_type st_q, st_d;
    logic [7:0] scratch_q [2];
    logic [7:0] scratch_d [2];
    logic [7:0] rdata_q, rdata_d;
    logic       oe_q, oe_d;
    logic [1:0] push, pop;
    logic       rch;
    logic [6:0] roff;

    always_comb begin
        st_d      = st_q;
        rdata_d   = rdata_q;
        oe_d      = 1'b0;
        wbyte_d   = wbyte_q;
        scratch_d = scratch_q;
        push      = 2'b00;
        pop       = 2'b00;
        rch       = addr >= host_port_pkg::chan_stride;
        roff      = rch ? addr - host_port_pkg::chan_stride : addr;
        case (st_q)
            host_port_pkg::idle_st: begin
                if (rd_act && acc_sel) begin
                    st_d = host_port_pkg::read_st;
                    oe_d = 1'b1;
                    case (roff)
                        host_port_pkg::fifo_data_addr: begin
                            rdata_d = rxf_out_data[rch*8 +: 8];
                            pop[rch] = rxf_out_valid[rch];
                        end
                        host_port_pkg::fifo_level_addr: rdata_d = 8'(rx_lvl[rch]);
                        host_port_pkg::scratch_addr:    rdata_d = scratch_q[rch];
                        host_port_pkg::status_addr:     rdata_d = 8'(tx_lvl[rch]);
                        default:                        rdata_d = host_port_pkg::unmapped_value;
                    endcase
                end else if (rd_act && acc_dma) begin
                    st_d = host_port_pkg::read_st;
                    oe_d = 1'b1;
                    rdata_d = rxf_out_data[chan_dma*8 +: 8];
                    pop[chan_dma] = rxf_out_valid[chan_dma];
                end else if (wr_act && acc_sel) begin
                    st_d = host_port_pkg::write_st;
                    wbyte_d = din;
                    if (roff == host_port_pkg::scratch_addr) begin
                        scratch_d[rch] = din;
                    end else if (roff == host_port_pkg::fifo_data_addr) begin
                        push[rch] = 1'b1;
                    end
                end else if (wr_act && acc_dma) begin
                    st_d = host_port_pkg::write_st;
                    wbyte_d = din;
                    push[chan_dma] = 1'b1;
                end
            end
            host_port_pkg::read_st: begin
                oe_d = rd_act && (acc_sel || acc_dma);
                if (!oe_d) begin
                    st_d = host_port_pkg::idle_st;
                end
            end
            host_port_pkg::write_st: begin
                if (!wr_act) begin
                    st_d = host_port_pkg::idle_st;
                end
            end
            default: st_d = host_port_pkg::idle_st;
        endcase
    end

    // push lands one cycle later with the captured byte; drops if full
    logic [1:0] push_q;
    always_comb begin
        txf_in_valid  = push_q;
        rxf_out_ready = pop;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q         <= host_port_pkg::idle_st;
            rdata_q      <= 8'h00;
            oe_q         <= 1'b0;
            wbyte_q      <= 8'h00;
            push_q       <= 2'b00;
            scratch_q[0] <= host_port_pkg::scratch_reset;
            scratch_q[1] <= host_port_pkg::scratch_reset;
        end else begin
            st_q      <= st_d;
            rdata_q   <= rdata_d;
            oe_q      <= oe_d;
            wbyte_q   <= wbyte_d;
            push_q    <= push;
            scratch_q <= scratch_d;
        end
    end

    // pin drivers straight from flip-flops
    assign host_data_lines_out = rdata_q;
    assign host_data_lines_oe  = oe_q;
endmodule

// File: shared/host_port_pkg.sv
// package: constants and types for the host bus port
package host_port_pkg;
    localparam int          data_width      = 8;
    localparam int          addr_width      = 7;
    localparam int          fifo_depth      = 64;
    localparam int          channel_count   = 2;
    // address map of the internal register window
    localparam logic [6:0]  fifo_data_addr  = 7'h00;
    localparam logic [6:0]  fifo_level_addr = 7'h01;
    localparam logic [6:0]  scratch_addr    = 7'h02;
    localparam logic [6:0]  status_addr     = 7'h03;
    localparam logic [6:0]  chan_stride     = 7'h40;
    localparam logic [7:0]  scratch_reset   = 8'h00;
    localparam logic [7:0]  unmapped_value  = 8'h00;

    // bus cycle sequencer states
    typedef enum logic [2:0] {
        idle_st   = 3'b001,
        read_st   = 3'b010,
        write_st  = 3'b100
    } cycle_state_type;
endpackage

// File: test/host_bus_port_test.sv
// testbench for the host bus port
`timescale 1ns/10ps
module host_bus_port_test;
    logic clk = 0, rst = 1, sel_n = 1, c1 = 1, c0 = 1, sty = 0, pol = 0, stall = 1, src = 0, oe;
    logic [7:0] din = 8'h00, dout, rd_v;
    logic [6:0] adr = 7'h00;
    logic [1:0] gnt = 2'h0, txv, txr, rxv, rxr;
    logic [15:0] txd, rxd;
    int err_total = 0, tests_run = 0;
    host_bus_port #(.depth(8)) i_host_bus_port (.clk(clk), .rst(rst), .host_data_lines_in(din),
        .host_data_lines_out(dout), .host_data_lines_oe(oe), .register_address_lines(adr), .select_n(sel_n),
        .control_input_one(c1), .control_input_zero(c0), .dma_grant(gnt), .bus_style_strap(sty),
        .strobe_polarity_strap(pol), .tx_valid(txv), .tx_ready(txr), .tx_data(txd), .rx_valid(rxv),
        .rx_ready(rxr), .rx_data(rxd));
    stream_partner i_stream_partner (.clk(clk), .rst(rst), .stall(stall), .src_en(src), .tx_valid(txv),
        .tx_ready(txr), .tx_data(txd), .rx_valid(rxv), .rx_ready(rxr), .rx_data(rxd));
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one bus cycle, strobe held five cycles
    task acc(input logic s, input logic [1:0] g, input logic [6:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        #5;
        sel_n = !s;
        gnt = g;
        adr = a;
        din = w ? d : ~din;
        c1 = sty ? !pol : w;
        c0 = !w;
        repeat (5) @(posedge clk);
        #5;
        rd_v = dout;
        sel_n = 1;
        gnt = 2'h0;
        c1 = sty ? pol : 1'b1;
        c0 = 1;
        din = ~din;
        repeat (4) @(posedge clk);
        #5;
        chk({7'h00, oe}, 8'h00);
    endtask
    // scratch access in every bus style
    task t_regs;
        acc(1'b1, 2'h0, host_port_pkg::scratch_addr, 1'b0, 8'h00);
        chk(rd_v, host_port_pkg::scratch_reset);
        for (int m = 0; m < 3; m++) begin
            sty = m != 0;
            pol = m == 2;
            c1 = sty ? pol : 1'b1;
            acc(1'b1, 2'h0, host_port_pkg::scratch_addr, 1'b1, 8'h5a ^ m[7:0]);
            acc(1'b1, 2'h0, host_port_pkg::scratch_addr | host_port_pkg::chan_stride, 1'b1, 8'ha5);
            acc(1'b1, 2'h0, host_port_pkg::scratch_addr, 1'b0, 8'h00);
            chk(rd_v, 8'h5a ^ m[7:0]);
            acc(1'b1, 2'h0, host_port_pkg::scratch_addr | host_port_pkg::chan_stride, 1'b0, 8'h00);
            chk(rd_v, 8'ha5);
        end
        acc(1'b1, 2'h0, 7'h10, 1'b0, 8'h00);
        chk(rd_v, host_port_pkg::unmapped_value);
        acc(1'b0, 2'h0, host_port_pkg::scratch_addr, 1'b1, 8'hff);
        acc(1'b1, 2'h0, host_port_pkg::scratch_addr, 1'b0, 8'h00);
        chk(rd_v, 8'h58);
    endtask
    // granted writes overfill channel one transmit fifo
    task t_tx;
        for (int i = 0; i < 9; i++) acc(1'b0, 2'h2, 7'h7f - i[6:0], 1'b1, 8'hc0 + i[7:0]);
        acc(1'b1, 2'h0, host_port_pkg::status_addr | host_port_pkg::chan_stride, 1'b0, 8'h00);
        chk(rd_v, 8'h08);
        stall = 0;
        repeat (12) @(posedge clk);
        #5;
        chk(8'(i_stream_partner.q.size()), 8'h08);
        for (int i = 0; i < 8; i++) chk(i_stream_partner.q.pop_front(), 8'hc0 + i[7:0]);
    endtask
    // receive fifo fills, granted reads drain it
    task t_rx;
        src = 1;
        repeat (20) @(posedge clk);
        #5;
        chk({6'h00, rxr}, 8'h02);
        src = 0;
        acc(1'b1, 2'h0, host_port_pkg::fifo_level_addr, 1'b0, 8'h00);
        chk(rd_v, 8'h08);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, 2'h1, 7'h55, 1'b0, 8'h00);
            chk(rd_v, i[7:0]);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #5;
        rst = 0;
        t_regs;
        t_tx;
        t_rx;
        summarize;
    end
    initial begin
        #200000;
        err_total++;
        summarize;
    end
endmodule

// File: test/host_port_asserts.sv
// checker: host bus port driver timing
`timescale 1ns/10ps
module host_port_asserts #(
    parameter int depth = 64
) (
    // watched ports
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] host_data_lines_out,
    input wire logic       host_data_lines_oe,
    input wire logic       select_n,
    input wire logic       control_input_one,
    input wire logic       control_input_zero,
    input wire logic [1:0] dma_grant,
    input wire logic       bus_style_strap,
    input wire logic       strobe_polarity_strap,
    input wire logic [1:0] tx_valid,
    input wire logic [1:0] rx_ready
);
    logic on;
    logic en;
    logic rd;
    logic wr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // pin-level access decode
    assign on = !select_n || (dma_grant != 2'h0);
    assign en = strobe_polarity_strap ? !control_input_one : control_input_one;
    assign rd = on && (bus_style_strap ? en && control_input_zero : !control_input_one);
    assign wr = on && (bus_style_strap ? en && !control_input_zero : !control_input_zero && control_input_one);
    oe_needs_read_a: assert property (host_data_lines_oe |-> $past(rd, 3) || $past(rd, 4))
        else $error("drive without read");
    read_drives_a: assert property (rd [*5] |-> host_data_lines_oe)
        else $error("read not driven");
    write_quiet_a: assert property (wr [*5] |-> !host_data_lines_oe)
        else $error("write drives bus");
    idle_quiet_a: assert property (!on [*5] |-> !host_data_lines_oe)
        else $error("idle drives bus");
    oe_onset_a: assert property ($rose(host_data_lines_oe) |-> $past(rd, 2) && $past(rd, 3))
        else $error("drive onset wrong");
    data_hold_a: assert property (host_data_lines_oe && $past(host_data_lines_oe) |-> $stable(host_data_lines_out))
        else $error("read data moved");
    rx_open_a: assert property ($fell(rst) |-> rx_ready == 2'h3)
        else $error("rx fifo not open");
    tx_empty_a: assert property ($fell(rst) |-> tx_valid == 2'h0)
        else $error("tx fifo not empty");
endmodule
bind host_bus_port host_port_asserts #(.depth(depth)) i_host_port_asserts (.clk(clk), .rst(rst),
    .host_data_lines_out(host_data_lines_out), .host_data_lines_oe(host_data_lines_oe), .select_n(select_n),
    .control_input_one(control_input_one), .control_input_zero(control_input_zero), .dma_grant(dma_grant),
    .bus_style_strap(bus_style_strap), .strobe_polarity_strap(strobe_polarity_strap), .tx_valid(tx_valid),
    .rx_ready(rx_ready));

// File: test/stream_partner.sv
// partner: receive byte source and transmit byte sink
`timescale 1ns/10ps
module stream_partner (
    // clock, reset, control
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall,
    input  wire logic        src_en,
    // stream pins
    input  wire logic [1:0]  tx_valid,
    output logic      [1:0]  tx_ready,
    input  wire logic [15:0] tx_data,
    output logic      [1:0]  rx_valid,
    input  wire logic [1:0]  rx_ready,
    output logic      [15:0] rx_data
);
    logic [7:0] q [$];
    logic [7:0] n_q;
    // sink stalls on request, idle lanes show the inverse
    assign tx_ready = {2{!stall}};
    assign rx_valid = {1'b0, src_en};
    assign rx_data  = {~n_q, src_en ? n_q : ~n_q};
    // count sent bytes, log received bytes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            n_q <= 8'h00;
        end else begin
            if (rx_valid[0] && rx_ready[0]) n_q <= n_q + 8'h01;
            for (int c = 0; c < 2; c++) if (tx_valid[c] && tx_ready[c]) q.push_back(tx_data[c*8+:8]);
        end
    end
endmodule
